/* pkg/sbd_pkg.sv */
package sbd_pkg;

	// --------------------------------------------------------------
	// host I/O map
	// --------------------------------------------------------------
	localparam int IO_ADDR_W = 16;
	localparam logic [15:0] SERIAL_CHAN_A_DATA_ADDR = 16'h00D8;
	localparam logic [15:0] SERIAL_CHAN_B_DATA_ADDR = 16'h00DA;
	localparam logic [15:0] SERIAL_CHAN_A_CONTROL_ADDR = 16'h00DC;
	localparam logic [15:0] SERIAL_CHAN_B_CONTROL_ADDR = 16'h00DE;
	localparam logic [15:0] BREAK_IRQ_CLEAR_ADDR = 16'h00E6;
	localparam logic [7:0] BREAK_CLEAR_VALUE = 8'h00;
	localparam int CHAN_BIT = 1;
	localparam int CTRL_BIT = 2;

	// --------------------------------------------------------------
	// line levels and reset values
	// --------------------------------------------------------------
	localparam logic SPACE_LEVEL = 1'b0;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam int SYNC_STAGES = 2;
	// strap samples taken after reset; the last one sees real pin levels
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	// one 11-bit character at 9600 baud
	localparam int CHAR_TIME_NS = 1145834;
	localparam int BREAK_CYCLES_DEF = (CHAR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BREAK_CNT_W = 24;

	// --------------------------------------------------------------
	// host access sequencer
	// --------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_ACTIVE = 3'b010,
		ST_RELEASE = 3'b100
	} sbd_state_t;

endpackage : sbd_pkg

/* pkg/sbd_brk_if.sv */
`timescale 1ns/1ps
// carries one channel's sampled receive line to its detector and the verdict back
interface sbd_brk_if;
	logic rx_line;
	logic hit;
	logic in_break;

	modport det
	(
		input rx_line,
		output hit,
		output in_break
	);

	modport owner
	(
		output rx_line,
		input hit,
		input in_break
	);
endinterface : sbd_brk_if

/* hw/sbd_sync.sv */
`timescale 1ns/1ps
// two flip-flop synchroniser for a group of asynchronous inputs
module sbd_sync
	import sbd_pkg::*;
#(
	parameter int WIDTH = 1
)
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] reset_val_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// first stage is read by the second stage only
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	// before the first samples land, report the idle level the caller chose;
	// the second stage holds a pin sample only from the second edge on
	logic [1:0] primed_reg;
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			primed_reg <= 2'h0;
		else
			primed_reg <= {primed_reg[0], 1'b1};
	end

	assign sync_out = primed_reg[1] ? sync_reg : reset_val_in;
endmodule : sbd_sync

/* hw/sbd_break_det.sv */
`timescale 1ns/1ps
// one channel's break detector: counts cycles of continuous space level
module sbd_break_det
	import sbd_pkg::*;
#(
	parameter int BREAK_CYCLES = BREAK_CYCLES_DEF
)
(
	input wire logic clock_in,
	input wire logic rst_in,
	sbd_brk_if.det brk
);
	logic [BREAK_CNT_W-1:0] run_reg;
	logic [BREAK_CNT_W-1:0] run_next;
	logic hit_reg;
	logic hit_next;
	logic in_break_reg;
	logic in_break_next;

	// any mark bit restarts the run; the count saturates so one break gives one hit
	always_comb
	begin
		run_next = run_reg;
		hit_next = 1'b0;
		in_break_next = in_break_reg;
		if (brk.rx_line != SPACE_LEVEL)
		begin
			run_next = '0;
			in_break_next = 1'b0;
		end
		else if (!in_break_reg)
		begin
			if (run_reg == BREAK_CNT_W'(BREAK_CYCLES - 1))
			begin
				hit_next = 1'b1;
				in_break_next = 1'b1;
			end
			else
				run_next = run_reg + 1'b1;
		end
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			run_reg <= '0;
			hit_reg <= 1'b0;
			in_break_reg <= 1'b0;
		end
		else
		begin
			run_reg <= run_next;
			hit_reg <= hit_next;
			in_break_reg <= in_break_next;
		end
	end

	assign brk.hit = hit_reg;
	assign brk.in_break = in_break_reg;
endmodule : sbd_break_det

/* hw/sbd_top.sv */
`timescale 1ns/1ps
module sbd_top
	import sbd_pkg::*;
#(
	parameter int BREAK_CYCLES = BREAK_CYCLES_DEF
)
(
	input wire logic clock_in,
	input wire logic rst_in,
	// host I/O bus
	input wire logic [IO_ADDR_W-1:0] io_addr_in,
	input wire logic io_rd_n_in,
	input wire logic io_wr_n_in,
	input wire logic io_byte_in,
	input wire logic [7:0] io_data_in,
	output logic [7:0] io_data_out,
	output logic io_data_oe_out,
	// dual serial controller side
	output logic ctl_sel_n_out,
	output logic ctl_chan_b_out,
	output logic ctl_control_out,
	output logic ctl_rd_n_out,
	output logic ctl_wr_n_out,
	output logic [7:0] ctl_wdata_out,
	input wire logic [7:0] ctl_rdata_in,
	input wire logic ctl_irq_in,
	// receive data lines of both channels
	input wire logic chan_a_rxd_in,
	input wire logic chan_b_rxd_in,
	// clock sources
	input wire logic timer_out1_in,
	input wire logic timer_out2_in,
	input wire logic chan_a_ext_rx_timing_in,
	input wire logic chan_a_ext_tx_timing_in,
	input wire logic chan_b_ext_tx_timing_in,
	// straps, high selects the external source; chan_b_rx_from_tx_sel_in high selects channel B's transmit clock
	input wire logic chan_a_rx_ext_sel_in,
	input wire logic chan_a_tx_ext_sel_in,
	input wire logic chan_b_tx_ext_sel_in,
	input wire logic chan_b_rx_from_tx_sel_in,
	// clocks to the controller and interrupt requests
	output logic chan_a_tx_clock_out,
	output logic chan_a_rx_clock_out,
	output logic chan_b_tx_clock_out,
	output logic chan_b_rx_clock_out,
	output logic irq_line_6_out,
	output logic break_irq_out
);

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	localparam int BUS_W = IO_ADDR_W + 8 + 3;
	localparam int PIN_W = 8 + 1 + 2 + 5 + 4;

	logic [BUS_W-1:0] bus_s;
	logic [PIN_W-1:0] pin_s;
	logic [IO_ADDR_W-1:0] addr_s;
	logic [7:0] wdata_s;
	logic rd_s;
	logic wr_s;
	logic byte_s;
	logic [7:0] rdata_s;
	logic ctl_irq_s;
	logic rxd_a_s;
	logic rxd_b_s;
	logic timer1_s;
	logic timer2_s;
	logic ext_a_rx_s;
	logic ext_a_tx_s;
	logic ext_b_tx_s;
	logic [3:0] strap_s;

	// strobes idle high, receive lines idle at mark
	sbd_sync #(.WIDTH(BUS_W)) u_bus_sync
	(
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in({io_addr_in, io_data_in, io_rd_n_in, io_wr_n_in, io_byte_in}),
		.reset_val_in({{(IO_ADDR_W + 8){1'b0}}, 3'b110}),
		.sync_out(bus_s)
	);

	sbd_sync #(.WIDTH(PIN_W)) u_pin_sync
	(
		.clock_in(clock_in),
		.rst_in(rst_in),
		.async_in({ctl_rdata_in, ctl_irq_in, chan_a_rxd_in, chan_b_rxd_in, timer_out1_in,
			timer_out2_in, chan_a_ext_rx_timing_in, chan_a_ext_tx_timing_in,
			chan_b_ext_tx_timing_in, chan_a_rx_ext_sel_in, chan_a_tx_ext_sel_in,
			chan_b_tx_ext_sel_in, chan_b_rx_from_tx_sel_in}),
		.reset_val_in({9'h000, ~SPACE_LEVEL, ~SPACE_LEVEL, 9'h000}),
		.sync_out(pin_s)
	);

	assign {addr_s, wdata_s} = bus_s[BUS_W-1:3];
	assign rd_s = ~bus_s[2];
	assign wr_s = ~bus_s[1];
	assign byte_s = bus_s[0];
	assign {rdata_s, ctl_irq_s, rxd_a_s, rxd_b_s, timer1_s, timer2_s} = pin_s[PIN_W-1:7];
	assign {ext_a_rx_s, ext_a_tx_s, ext_b_tx_s, strap_s} = pin_s[6:0];

	// --------------------------------------------------------------
	// strap capture
	// --------------------------------------------------------------
	// jumpers are static: sampled until the synchronisers carry pin levels, then held
	logic [3:0] strap_reg;
	logic [3:0] strap_next;
	logic [1:0] strap_age_reg;
	logic [1:0] strap_age_next;

	always_comb
	begin
		strap_next = strap_reg;
		strap_age_next = strap_age_reg;
		if (strap_age_reg != STRAP_SETTLE_CYCLES)
			{strap_age_next, strap_next} = {strap_age_reg + 2'h1, strap_s};
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			strap_reg <= 4'h0;
			strap_age_reg <= 2'h0;
		end
		else
		begin
			strap_reg <= strap_next;
			strap_age_reg <= strap_age_next;
		end
	end

	// --------------------------------------------------------------
	// host access decode and sequencer
	// --------------------------------------------------------------
	sbd_state_t state_reg;
	sbd_state_t state_next;
	logic hit_ser;
	logic hit_clr;
	logic ser_read_reg;
	logic ser_read_next;
	logic ctl_sel_next;
	logic ctl_chan_b_next;
	logic ctl_control_next;
	logic ctl_rd_next;
	logic ctl_wr_next;
	logic [7:0] ctl_wdata_next;
	logic [7:0] io_data_next;
	logic io_oe_next;
	logic clr_pulse;
	logic ctl_sel_reg;
	logic ctl_rd_reg;
	logic ctl_wr_reg;

	// only byte cycles to the serial ports or the clear port are claimed
	always_comb
	begin
		hit_ser = 1'b0;
		hit_clr = 1'b0;
		if (!byte_s)
			hit_ser = 1'b0;
		else if (addr_s == SERIAL_CHAN_A_DATA_ADDR)
			hit_ser = 1'b1;
		else if (addr_s == SERIAL_CHAN_B_DATA_ADDR)
			hit_ser = 1'b1;
		else if (addr_s == SERIAL_CHAN_A_CONTROL_ADDR)
			hit_ser = 1'b1;
		else if (addr_s == SERIAL_CHAN_B_CONTROL_ADDR)
			hit_ser = 1'b1;
		else if (addr_s == BREAK_IRQ_CLEAR_ADDR)
			hit_clr = 1'b1;
	end

	// one access per strobe; a release state waits for the strobe to drop
	always_comb
	begin
		state_next = state_reg;
		ser_read_next = ser_read_reg;
		ctl_sel_next = ctl_sel_reg;
		ctl_chan_b_next = ctl_chan_b_out;
		ctl_control_next = ctl_control_out;
		ctl_rd_next = ctl_rd_reg;
		ctl_wr_next = ctl_wr_reg;
		ctl_wdata_next = ctl_wdata_out;
		io_data_next = io_data_out;
		io_oe_next = io_data_oe_out;
		clr_pulse = 1'b0;
		case (state_reg)
			ST_IDLE:
			begin
				if ((rd_s || wr_s) && hit_ser)
				begin
					state_next = ST_ACTIVE;
					ctl_sel_next = 1'b1;
					ctl_chan_b_next = addr_s[CHAN_BIT];
					ctl_control_next = addr_s[CTRL_BIT];
					ctl_rd_next = rd_s;
					ctl_wr_next = wr_s && !rd_s;
					ctl_wdata_next = wdata_s;
					ser_read_next = rd_s;
				end
				else if (rd_s || wr_s)
				begin
					state_next = ST_RELEASE;
					clr_pulse = wr_s && !rd_s && hit_clr && (wdata_s == BREAK_CLEAR_VALUE);
				end
			end
			ST_ACTIVE:
			begin
				// read data is refreshed while the controller drives it
				if (ser_read_reg)
				begin
					io_data_next = rdata_s;
					io_oe_next = 1'b1;
				end
				if (!rd_s && !wr_s)
				begin
					state_next = ST_IDLE;
					ctl_sel_next = 1'b0;
					ctl_rd_next = 1'b0;
					ctl_wr_next = 1'b0;
					io_oe_next = 1'b0;
					ser_read_next = 1'b0;
				end
			end
			ST_RELEASE:
			begin
				if (!rd_s && !wr_s)
					state_next = ST_IDLE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_reg <= ST_IDLE;
			ser_read_reg <= 1'b0;
			ctl_sel_reg <= 1'b0;
			ctl_chan_b_out <= 1'b0;
			ctl_control_out <= 1'b0;
			ctl_rd_reg <= 1'b0;
			ctl_wr_reg <= 1'b0;
			ctl_wdata_out <= RDATA_RESET;
			io_data_out <= RDATA_RESET;
			io_data_oe_out <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			ser_read_reg <= ser_read_next;
			ctl_sel_reg <= ctl_sel_next;
			ctl_chan_b_out <= ctl_chan_b_next;
			ctl_control_out <= ctl_control_next;
			ctl_rd_reg <= ctl_rd_next;
			ctl_wr_reg <= ctl_wr_next;
			ctl_wdata_out <= ctl_wdata_next;
			io_data_out <= io_data_next;
			io_data_oe_out <= io_oe_next;
		end
	end

	assign ctl_sel_n_out = ~ctl_sel_reg;
	assign ctl_rd_n_out = ~ctl_rd_reg;
	assign ctl_wr_n_out = ~ctl_wr_reg;

	// --------------------------------------------------------------
	// break detectors and latch
	// --------------------------------------------------------------
	// fed straight from the pins, never from the controller, so a remote
	// station can interrupt a board whose controller was never programmed
	sbd_brk_if brk_a ();
	sbd_brk_if brk_b ();

	assign brk_a.rx_line = rxd_a_s;
	assign brk_b.rx_line = rxd_b_s;

	sbd_break_det #(.BREAK_CYCLES(BREAK_CYCLES)) u_det_a
	(
		.clock_in(clock_in),
		.rst_in(rst_in),
		.brk(brk_a)
	);

	sbd_break_det #(.BREAK_CYCLES(BREAK_CYCLES)) u_det_b
	(
		.clock_in(clock_in),
		.rst_in(rst_in),
		.brk(brk_b)
	);

	logic brk_latch_reg;
	logic brk_latch_next;

	// a new break in the clearing cycle wins, so no break is lost
	always_comb
	begin
		brk_latch_next = brk_latch_reg;
		if (brk_a.hit || brk_b.hit)
			brk_latch_next = 1'b1;
		else if (clr_pulse)
			brk_latch_next = 1'b0;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			brk_latch_reg <= 1'b0;
		else
			brk_latch_reg <= brk_latch_next;
	end

	assign break_irq_out = brk_latch_reg;

	// --------------------------------------------------------------
	// clock source selection and interrupt routing
	// --------------------------------------------------------------
	// outputs are resampled copies; edges move by two to three clocks,
	// which is small against the serial bit clocks
	logic a_tx_next;
	logic a_rx_next;
	logic b_tx_next;
	logic b_rx_next;

	always_comb
	begin
		a_tx_next = strap_reg[2] ? ext_a_tx_s : timer2_s;
		a_rx_next = strap_reg[3] ? ext_a_rx_s : a_tx_next;
		b_tx_next = strap_reg[1] ? ext_b_tx_s : timer1_s;
		b_rx_next = strap_reg[0] ? b_tx_next : timer1_s;
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			chan_a_tx_clock_out <= 1'b0;
			chan_a_rx_clock_out <= 1'b0;
			chan_b_tx_clock_out <= 1'b0;
			chan_b_rx_clock_out <= 1'b0;
			irq_line_6_out <= 1'b0;
		end
		else
		begin
			chan_a_tx_clock_out <= a_tx_next;
			chan_a_rx_clock_out <= a_rx_next;
			chan_b_tx_clock_out <= b_tx_next;
			chan_b_rx_clock_out <= b_rx_next;
			irq_line_6_out <= ctl_irq_s;
		end
	end

endmodule : sbd_top

/* sim/sbd_top_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// break, decode and routing checks at the top ports
// ----------------------------------------
module sbd_chk
	import sbd_pkg::*;
#(
	parameter int BREAK_CYCLES = BREAK_CYCLES_DEF
)
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [IO_ADDR_W-1:0] io_addr_in,
	input wire logic io_wr_n_in,
	input wire logic io_byte_in,
	input wire logic [7:0] io_data_in,
	input wire logic io_data_oe_out,
	input wire logic ctl_sel_n_out,
	input wire logic ctl_chan_b_out,
	input wire logic ctl_control_out,
	input wire logic ctl_wr_n_out,
	input wire logic [7:0] ctl_wdata_out,
	input wire logic ctl_irq_in,
	input wire logic chan_a_rxd_in,
	input wire logic chan_b_rxd_in,
	input wire logic timer_out1_in,
	input wire logic timer_out2_in,
	input wire logic chan_a_ext_rx_timing_in,
	input wire logic chan_a_ext_tx_timing_in,
	input wire logic chan_b_ext_tx_timing_in,
	input wire logic chan_a_rx_ext_sel_in,
	input wire logic chan_a_tx_ext_sel_in,
	input wire logic chan_b_tx_ext_sel_in,
	input wire logic chan_b_rx_from_tx_sel_in,
	input wire logic chan_a_tx_clock_out,
	input wire logic chan_a_rx_clock_out,
	input wire logic chan_b_tx_clock_out,
	input wire logic chan_b_rx_clock_out,
	input wire logic irq_line_6_out,
	input wire logic break_irq_out
);
	logic [7:0] run_a_reg, run_a_next, run_b_reg, run_b_next;
	logic [2:0] up_reg, up_next;
	logic clr;
	logic up_ok;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);

	// pin-level space runs; routing checks wait until the sync stages have filled
	always_comb
	begin
		run_a_next = chan_a_rxd_in ? 8'h00 : run_a_reg + {7'h00, run_a_reg != 8'hFF};
		run_b_next = chan_b_rxd_in ? 8'h00 : run_b_reg + {7'h00, run_b_reg != 8'hFF};
		up_next = up_reg + {2'h0, up_reg != 3'h7};
	end

	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			run_a_reg <= 8'h00;
			run_b_reg <= 8'h00;
			up_reg <= 3'h0;
		end
		else
		begin
			run_a_reg <= run_a_next;
			run_b_reg <= run_b_next;
			up_reg <= up_next;
		end
	end

	assign up_ok = up_reg == 3'h7;
	assign clr = !io_wr_n_in && io_byte_in && io_addr_in == BREAK_IRQ_CLEAR_ADDR
		&& io_data_in == BREAK_CLEAR_VALUE;

	a_brk_sets: assert property ((run_a_reg == BREAK_CYCLES + 6 ||
		run_b_reg == BREAK_CYCLES + 6) |-> break_irq_out) else $error("break not flagged");
	a_brk_not_early: assert property ($rose(break_irq_out) |->
		($past(run_a_reg, 2) >= BREAK_CYCLES - 2 || $past(run_b_reg, 2) >= BREAK_CYCLES - 2))
		else $error("break flagged too early");
	a_brk_latched: assert property ($fell(break_irq_out) |->
		($past(clr, 2) || $past(clr, 3) || $past(clr, 4))) else $error("break dropped alone");
	a_clear_acts: assert property ($rose(clr) |-> ##[2:6] !break_irq_out)
		else $error("clear write ignored");
	a_irq6_route: assert property (up_ok |-> irq_line_6_out == $past(ctl_irq_in, 3))
		else $error("irq line 6 wrong");
	a_tx_a_route: assert property (up_ok |-> chan_a_tx_clock_out ==
		(chan_a_tx_ext_sel_in ? $past(chan_a_ext_tx_timing_in, 3) : $past(timer_out2_in, 3)))
		else $error("tx clock A wrong");
	a_rx_a_route: assert property (up_ok |-> chan_a_rx_clock_out ==
		(chan_a_rx_ext_sel_in ? $past(chan_a_ext_rx_timing_in, 3) : chan_a_tx_clock_out))
		else $error("rx clock A wrong");
	a_tx_b_route: assert property (up_ok |-> chan_b_tx_clock_out ==
		(chan_b_tx_ext_sel_in ? $past(chan_b_ext_tx_timing_in, 3) : $past(timer_out1_in, 3)))
		else $error("tx clock B wrong");
	a_rx_b_route: assert property (up_ok |-> chan_b_rx_clock_out ==
		(chan_b_rx_from_tx_sel_in ? chan_b_tx_clock_out : $past(timer_out1_in, 3)))
		else $error("rx clock B wrong");
	a_sel_decode: assert property ($fell(ctl_sel_n_out) |-> $past(io_byte_in, 3) &&
		($past(io_addr_in, 3) & 16'hFFF9) == 16'h00D8
		&& ctl_chan_b_out == $past(io_addr_in[CHAN_BIT], 3)
		&& ctl_control_out == $past(io_addr_in[CTRL_BIT], 3)) else $error("bad select decode");
	a_wdata_pass: assert property ($fell(ctl_wr_n_out) |->
		ctl_wdata_out == $past(io_data_in, 3)) else $error("write data wrong");

	c_brk_rise: cover property ($rose(break_irq_out));
	c_brk_fall: cover property ($fell(break_irq_out));
	c_ctl_write: cover property ($fell(ctl_wr_n_out));
	c_host_read: cover property ($rose(io_data_oe_out));
endmodule : sbd_chk

bind sbd_top sbd_chk #(.BREAK_CYCLES(BREAK_CYCLES)) sbd_chk_inst (.clock_in(clock_in),
	.rst_in(rst_in), .io_addr_in(io_addr_in), .io_wr_n_in(io_wr_n_in), .io_byte_in(io_byte_in),
	.io_data_in(io_data_in), .io_data_oe_out(io_data_oe_out), .ctl_sel_n_out(ctl_sel_n_out),
	.ctl_chan_b_out(ctl_chan_b_out), .ctl_control_out(ctl_control_out),
	.ctl_wr_n_out(ctl_wr_n_out), .ctl_wdata_out(ctl_wdata_out), .ctl_irq_in(ctl_irq_in),
	.chan_a_rxd_in(chan_a_rxd_in), .chan_b_rxd_in(chan_b_rxd_in),
	.timer_out1_in(timer_out1_in), .timer_out2_in(timer_out2_in),
	.chan_a_ext_rx_timing_in(chan_a_ext_rx_timing_in),
	.chan_a_ext_tx_timing_in(chan_a_ext_tx_timing_in),
	.chan_b_ext_tx_timing_in(chan_b_ext_tx_timing_in),
	.chan_a_rx_ext_sel_in(chan_a_rx_ext_sel_in), .chan_a_tx_ext_sel_in(chan_a_tx_ext_sel_in),
	.chan_b_tx_ext_sel_in(chan_b_tx_ext_sel_in),
	.chan_b_rx_from_tx_sel_in(chan_b_rx_from_tx_sel_in),
	.chan_a_tx_clock_out(chan_a_tx_clock_out), .chan_a_rx_clock_out(chan_a_rx_clock_out),
	.chan_b_tx_clock_out(chan_b_tx_clock_out),
	.chan_b_rx_clock_out(chan_b_rx_clock_out), .irq_line_6_out(irq_line_6_out),
	.break_irq_out(break_irq_out));

/* sim/sbd_ser_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// serial controller stand-in: four byte registers
// ----------------------------------------
module sbd_ser_model
(
	input wire logic clock_in,
	input wire logic sel_n_in,
	input wire logic chan_b_in,
	input wire logic control_in,
	input wire logic rd_n_in,
	input wire logic wr_n_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] regs [4];

	initial rdata_out = 8'h5A;

	// idle data flips each cycle so a stale byte never passes for a read
	always @(posedge clock_in)
	begin
		if (!sel_n_in && !wr_n_in)
			regs[{control_in, chan_b_in}] <= wdata_in;
		rdata_out <= (!sel_n_in && !rd_n_in) ? regs[{control_in, chan_b_in}] : ~rdata_out;
	end
endmodule : sbd_ser_model

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
	import sbd_pkg::*;
	localparam int BRK = 16;
	logic clock_in, rst_in, io_rd_n_in, io_wr_n_in, io_byte_in, ctl_irq_in, lclk;
	logic [3:0] strap;
	logic [15:0] io_addr_in;
	logic [7:0] io_data_in, io_data_out, ctl_wdata_out, ctl_rdata_in, last_rd;
	logic io_data_oe_out, ctl_sel_n_out, ctl_chan_b_out, ctl_control_out, ctl_rd_n_out;
	logic ctl_wr_n_out, rxd_a, rxd_b, tmr1, tmr2, ext_rx, ext_tx_a, ext_tx_b, brk;
	logic sel_p, oe_p, brk_p;
	logic [7:0] mem [4];
	logic [17:0] q [$];
	int num_errors, n_compared, i;

	sbd_top #(.BREAK_CYCLES(BRK)) sbd_top_inst (.clock_in(clock_in), .rst_in(rst_in),
		.io_addr_in(io_addr_in), .io_rd_n_in(io_rd_n_in), .io_wr_n_in(io_wr_n_in),
		.io_byte_in(io_byte_in), .io_data_in(io_data_in), .io_data_out(io_data_out),
		.io_data_oe_out(io_data_oe_out), .ctl_sel_n_out(ctl_sel_n_out),
		.ctl_chan_b_out(ctl_chan_b_out), .ctl_control_out(ctl_control_out),
		.ctl_rd_n_out(ctl_rd_n_out), .ctl_wr_n_out(ctl_wr_n_out), .ctl_wdata_out(ctl_wdata_out),
		.ctl_rdata_in(ctl_rdata_in), .ctl_irq_in(ctl_irq_in), .chan_a_rxd_in(rxd_a),
		.chan_b_rxd_in(rxd_b), .timer_out1_in(tmr1), .timer_out2_in(tmr2),
		.chan_a_ext_rx_timing_in(ext_rx), .chan_a_ext_tx_timing_in(ext_tx_a),
		.chan_b_ext_tx_timing_in(ext_tx_b), .chan_a_rx_ext_sel_in(strap[3]),
		.chan_a_tx_ext_sel_in(strap[2]), .chan_b_tx_ext_sel_in(strap[1]),
		.chan_b_rx_from_tx_sel_in(strap[0]), .chan_a_tx_clock_out(), .chan_a_rx_clock_out(),
		.chan_b_tx_clock_out(), .chan_b_rx_clock_out(), .irq_line_6_out(),
		.break_irq_out(brk));

	sbd_ser_model sbd_ser_model_inst (.clock_in(clock_in), .sel_n_in(ctl_sel_n_out),
		.chan_b_in(ctl_chan_b_out), .control_in(ctl_control_out), .rd_n_in(ctl_rd_n_out),
		.wr_n_in(ctl_wr_n_out), .wdata_in(ctl_wdata_out), .rdata_out(ctl_rdata_in));

	initial
	begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end

	// link clock for the timer source, phase unrelated to the board clock
	initial
	begin
		lclk = 1'b0;
		#17;
		forever #62.5 lclk = ~lclk;
	end

	// clock sources and controller interrupt are updated every cycle, tmr2 from lclk
	always @(posedge clock_in)
	begin
		tmr2 <= lclk;
		tmr1 <= 1'($urandom);
		ext_rx <= 1'($urandom);
		ext_tx_a <= 1'($urandom);
		ext_tx_b <= 1'($urandom);
		ctl_irq_in <= 1'($urandom);
	end

	task check_val(input logic [17:0] got);
		logic [17:0] exp;
		exp = (q.size() != 0) ? q.pop_front() : 18'h3FFFF;
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	// watcher: every visible result takes the oldest note
	always @(posedge clock_in)
	begin
		if (sel_p === 1'b1 && ctl_sel_n_out === 1'b0)
			check_val({2'd1, ctl_chan_b_out, ctl_control_out, ctl_wr_n_out, ctl_rd_n_out, 4'h0,
				ctl_wr_n_out ? 8'h00 : ctl_wdata_out});
		if (oe_p === 1'b1 && io_data_oe_out === 1'b0)
			check_val({2'd2, 8'h00, last_rd});
		if (brk_p !== brk)
			check_val({2'd3, 15'h0000, brk});
		if (io_data_oe_out === 1'b1)
			last_rd = io_data_out;
		sel_p = ctl_sel_n_out;
		oe_p = io_data_oe_out;
		brk_p = brk;
	end

	// one host strobe; notes what the controller side should show
	task io(input logic [15:0] a, input logic [7:0] d, input bit wr, input bit b);
		@(posedge clock_in);
		io_addr_in <= a;
		io_data_in <= d;
		io_byte_in <= b;
		if (wr)
			io_wr_n_in <= 1'b0;
		else
			io_rd_n_in <= 1'b0;
		if (b && (a & 16'hFFF9) == 16'h00D8)
		begin
			q.push_back({2'd1, a[1], a[2], !wr, wr, 4'h0, wr ? d : 8'h00});
			if (wr)
				mem[a[2:1]] = d;
			else
				q.push_back({2'd2, 8'h00, mem[a[2:1]]});
		end
		repeat (8) @(posedge clock_in);
		io_wr_n_in <= 1'b1;
		io_rd_n_in <= 1'b1;
		repeat (6) @(posedge clock_in);
	endtask : io

	// hold one receive line at space for n cycles
	task space(input bit ch, input int n);
		@(posedge clock_in);
		if (ch)
			rxd_b <= 1'b0;
		else
			rxd_a <= 1'b0;
		repeat (n) @(posedge clock_in);
		rxd_a <= 1'b1;
		rxd_b <= 1'b1;
		repeat (10) @(posedge clock_in);
	endtask : space

	task stop_test();
		if (q.size() != 0)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, 18'h0, q[0]);
		end
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	initial
	begin
		#100000;
		num_errors++;
		$display("watchdog expired at %0t", $time);
		stop_test();
	end

	initial
	begin
		{io_rd_n_in, io_wr_n_in, rxd_a, rxd_b, sel_p} = 5'h1F;
		{io_byte_in, ctl_irq_in, tmr1, tmr2, ext_rx, ext_tx_a, ext_tx_b, strap} = 11'h000;
		{oe_p, brk_p, io_addr_in, io_data_in, last_rd} = 34'h0;
		num_errors = 0;
		n_compared = 0;
		rst_in = 1'b1;
		void'($urandom(30));
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		for (i = 0; i < 4; i++)
			io(16'h00D8 + 16'(2 * i), 8'($urandom), 1'b1, 1'b1);
		for (i = 3; i >= 0; i--)
			io(16'h00D8 + 16'(2 * i), 8'h00, 1'b0, 1'b1);
		$display("test port access done");
		io(16'h00D8, 8'hA5, 1'b1, 1'b0);
		io(16'h00D9, 8'h3C, 1'b1, 1'b1);
		io(16'h01DA, 8'h3C, 1'b1, 1'b1);
		io(BREAK_IRQ_CLEAR_ADDR, 8'h00, 1'b0, 1'b1);
		$display("test refused access done");
		for (i = 0; i < 8; i++)
			space(1'($urandom), 1 + int'($urandom % (BRK - 4)));
		$display("test short space done");
		for (i = 0; i < 2; i++)
		begin
			q.push_back({2'd3, 16'h0001});
			space(i[0], BRK + 10);
			repeat (20) @(posedge clock_in);
			io(BREAK_IRQ_CLEAR_ADDR, 8'h01 | 8'($urandom), 1'b1, 1'b1);
			q.push_back({2'd3, 16'h0000});
			io(BREAK_IRQ_CLEAR_ADDR, BREAK_CLEAR_VALUE, 1'b1, 1'b1);
		end
		$display("test break latch done");
		rst_in <= 1'b1;
		strap <= 4'hF;
		repeat (2) @(posedge clock_in);
		rst_in <= 1'b0;
		repeat (40) @(posedge clock_in);
		$display("test external clocks done");
		stop_test();
	end
endmodule : tb
